// *** rtl/burst_flash_fetch_sequencer.sv ***
// Purpose: burst read sequencer for synchronous code flash
// Assumes: request side on core_clk_in, pins on fast_bus_clk_in (slower)
// Notes: config and request are held stable while busy and cross by toggle
//
// Behaviour
// - every access opens with an address phase of 1+ cycles on slow clock rise
// - command delay of 0+ cycles, then command phase of read wait count, min 1
// - burst phases of programmed length repeat until access length is done
// - recovery after reads; chip select change count when region differs
// - slow device clock is bus clock divided by 1, 2, 3 or 4
// - access start and page resume align to slow clock rise; phase counts and outputs timed on bus clock
// - strobes assert half a cycle late unless delay bypass is set
// - fetch burst length limits one access to 1, 2, 4 or 8 bursts
// - longer requests automatically issue further burst accesses
// - continuous burst ignores the fetch burst length limit
// - wait function bit: 0 page load wait, 1 terminate and restart
// - wait mode selects sync, async or disabled; disabled means no effect
// - page mode: finish burst, one more burst, then hold until wait high
// - page mode resume starts on next slow clock rise after wait high
// - page mode wait sampled on bus clock, resynced to slow clock rise
// - terminate mode: finish burst, end access, start fresh full access
// - restart uses next sequential address after recovery, slow aligned
// - the last burst of an access ends by releasing chip select then recovery
// - short or continuous bursts release chip select after last word
// - flash data width is 16 or 32 bits
`timescale 1ns/1ps
`include "flash_fetch_defs.svh"

module burst_flash_fetch_sequencer (
	input wire logic core_clk_in,
	input wire logic sys_rst_in,
	input wire logic fast_bus_clk_in,
	input wire logic fetch_req_in,
	input wire flash_fetch_pkg::fetch_req_s fetch_in,
	input wire flash_fetch_pkg::flash_cfg_s cfg_in,
	output logic fetch_ready_out,
	output logic [31:0] fetch_data_out,
	output logic fetch_data_valid_out,
	output logic fetch_done_out,
	input wire logic [31:0] flash_data_in,
	input wire logic flash_wait_n_in,
	output logic [23:1] flash_addr_out,
	output logic [7:0] flash_cs_n_out,
	output logic flash_rd_n_out,
	output logic address_valid_strobe_n_out,
	output logic burst_advance_strobe_n_out,
	output logic fast_bus_clock_out,
	output logic device_clock_out
);
	function automatic logic [3:0] len_m1(input logic [3:0] v);
		len_m1 = (v == `CNT_ZERO) ? `CNT_ZERO : v - `BEAT_ONE;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// core side: request capture and return path
	logic busy;
	logic req_tgl;
	flash_fetch_pkg::fetch_req_s hreq;
	flash_fetch_pkg::flash_cfg_s hcfg;
	logic done_tgl;
	logic word_tgl;
	logic [31:0] word_q;
	logic [2:0] done_sy;
	logic [2:0] word_sy;
	wire done_evt = done_sy[1] ^ done_sy[2];
	wire word_evt = word_sy[1] ^ word_sy[2];
	wire take_req = fetch_req_in && !busy;

	assign fetch_ready_out = !busy;

	always_ff @(posedge core_clk_in) begin
		if (sys_rst_in) begin
			busy <= 1'b0;
			req_tgl <= 1'b0;
			hreq <= '0;
			hcfg <= '0;
			done_sy <= 3'h0;
			word_sy <= 3'h0;
			fetch_done_out <= 1'b0;
			fetch_data_valid_out <= 1'b0;
			fetch_data_out <= 32'h00000000;
		end else begin
			done_sy <= {done_sy[1:0], done_tgl};
			word_sy <= {word_sy[1:0], word_tgl};
			fetch_done_out <= done_evt;
			fetch_data_valid_out <= word_evt;
			// word_q is stable for a whole bus clock after its toggle
			if (word_evt) begin
				fetch_data_out <= word_q;
			end
			if (take_req) begin
				hreq <= fetch_in;
				hcfg <= cfg_in;
				req_tgl <= !req_tgl;
				busy <= 1'b1;
			end else if (done_evt) begin
				busy <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// link side: reset, request sync, divider
	logic [1:0] rst_sy;
	wire rst_l = rst_sy[1];
	logic [2:0] req_sy;
	wire new_req = req_sy[1] ^ req_sy[2];
	logic [1:0] div_cnt;
	logic slow_q;
	wire [1:0] div_max = hcfg.clk_div;
	// decided one bus cycle early, since the pin registers lag the state by one cycle
	wire [1:0] div_lead = (div_max == `DIV_ZERO) ? `DIV_ZERO : div_max - 2'h1;
	wire slow_edge = (div_cnt == div_lead);
	wire [1:0] next_div = (div_cnt == div_max) ? `DIV_ZERO : div_cnt + 2'h1;
	// high for the first half of each slow period, odd ratios lean high
	wire next_slow = ({1'b0, next_div} < ({1'b0, div_max} + 3'h2) >> 1);

	always_ff @(posedge fast_bus_clk_in) begin
		rst_sy <= {rst_sy[0], sys_rst_in};
	end

	always_ff @(posedge fast_bus_clk_in) begin
		if (rst_l) begin
			req_sy <= 3'h0;
			div_cnt <= `DIV_ZERO;
			slow_q <= 1'b1;
		end else begin
			req_sy <= {req_sy[1:0], req_tgl};
			div_cnt <= next_div;
			slow_q <= next_slow;
		end
	end

	// ratio one cannot come from a flop, so the bus clock itself is passed
	assign device_clock_out = (div_max == `DIV_ZERO) ? fast_bus_clk_in : slow_q;
	assign fast_bus_clock_out = fast_bus_clk_in;

	////////////////////////////////////////////////////////////////////////
	// wait pin and data pin synchronisers
	logic [2:0] wait_sy;
	logic wait_slow;
	logic [31:0] dat_s1;
	logic [31:0] dat_s2;
	wire wait_samp = (hcfg.wait_mode == flash_fetch_pkg::WAIT_ASYNC) ? wait_sy[2] : wait_sy[1];
	wire wait_on = (hcfg.wait_mode != flash_fetch_pkg::WAIT_OFF);
	wire page_low = wait_on && !hcfg.wait_func && !wait_slow;
	wire term_low = wait_on && hcfg.wait_func && !wait_samp;

	always_ff @(posedge fast_bus_clk_in) begin
		if (rst_l) begin
			wait_sy <= 3'h7;
			wait_slow <= 1'b1;
			dat_s1 <= 32'h00000000;
			dat_s2 <= 32'h00000000;
		end else begin
			wait_sy <= {wait_sy[1:0], flash_wait_n_in};
			if (slow_edge) begin
				wait_slow <= wait_samp;
			end
			dat_s1 <= flash_data_in;
			dat_s2 <= dat_s1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// phase sequencer
	flash_fetch_pkg::link_state_e st;
	logic [3:0] cnt;
	logic [23:0] addr;
	logic [7:0] words_left;
	logic [3:0] beats;
	logic [1:0] pp;
	logic term;
	logic [2:0] last_cs;
	logic cs_valid;
	logic [1:0] cap;

	wire [3:0] blen = `BEAT_ONE << hcfg.fetch_burst_length;
	wire [23:0] step = hcfg.port_width ? `ADDR_STEP_32 : `ADDR_STEP_16;
	wire [3:0] beats_inc = beats + `BEAT_ONE;
	wire bp_end = (st == flash_fetch_pkg::ST_BURST) && (cnt == `CNT_ZERO);
	wire limit_hit = !hcfg.continuous_burst_select && (beats_inc == blen);
	wire last_bp = (words_left == 8'h01) || limit_hit || term || term_low;
	wire [1:0] pp_eff = (pp == `PP_NONE && page_low) ? `PP_ONE_MORE : pp;
	wire cs_moved = cs_valid && (last_cs != hreq.region_chip_select);
	wire caps_clear = (cap == 2'h0);

	always_ff @(posedge fast_bus_clk_in) begin
		if (rst_l) begin
			st <= flash_fetch_pkg::ST_IDLE;
			cnt <= `CNT_ZERO;
			addr <= 24'h000000;
			words_left <= 8'h00;
			beats <= `CNT_ZERO;
			pp <= `PP_NONE;
			term <= 1'b0;
			last_cs <= 3'h0;
			cs_valid <= 1'b0;
			cap <= 2'h0;
			done_tgl <= 1'b0;
			word_tgl <= 1'b0;
			word_q <= 32'h00000000;
		end else begin
			// data is two synchroniser stages behind the pins
			cap <= {cap[0], bp_end};
			if (cap[1]) begin
				word_q <= hcfg.port_width ? dat_s2 : {16'h0000, dat_s2[15:0]};
				word_tgl <= !word_tgl;
			end
			unique case (st)
				flash_fetch_pkg::ST_IDLE: begin
					if (new_req) begin
						addr <= hreq.addr;
						words_left <= hreq.words;
						st <= flash_fetch_pkg::ST_RECOV;
						cnt <= cs_moved ? len_m1(hcfg.cs_change_recovery_count) : `CNT_ZERO;
					end
				end
				flash_fetch_pkg::ST_ADDR: begin
					if (cnt != `CNT_ZERO) begin
						cnt <= cnt - `BEAT_ONE;
					end else if (hcfg.command_delay_count == `CNT_ZERO) begin
						st <= flash_fetch_pkg::ST_CMD;
						cnt <= len_m1(hcfg.read_wait_count);
					end else begin
						st <= flash_fetch_pkg::ST_CDLY;
						cnt <= hcfg.command_delay_count - `BEAT_ONE;
					end
				end
				flash_fetch_pkg::ST_CDLY: begin
					if (cnt != `CNT_ZERO) begin
						cnt <= cnt - `BEAT_ONE;
					end else begin
						st <= flash_fetch_pkg::ST_CMD;
						cnt <= len_m1(hcfg.read_wait_count);
					end
				end
				flash_fetch_pkg::ST_CMD: begin
					if (cnt != `CNT_ZERO) begin
						cnt <= cnt - `BEAT_ONE;
					end else begin
						st <= flash_fetch_pkg::ST_BURST;
						cnt <= len_m1(hcfg.burst_cycle_count);
					end
				end
				flash_fetch_pkg::ST_BURST: begin
					if (term_low) begin
						term <= 1'b1;
					end
					if (cnt != `CNT_ZERO) begin
						cnt <= cnt - `BEAT_ONE;
						pp <= pp_eff;
					end else begin
						addr <= addr + step;
						words_left <= words_left - 8'h01;
						beats <= beats_inc;
						if (last_bp) begin
							st <= flash_fetch_pkg::ST_RECOV;
							cnt <= len_m1(hcfg.read_recovery_count);
							pp <= `PP_NONE;
						end else if (pp_eff == `PP_HOLD_NEXT) begin
							st <= flash_fetch_pkg::ST_HOLD;
							pp <= `PP_NONE;
						end else begin
							cnt <= len_m1(hcfg.burst_cycle_count);
							pp <= (pp_eff == `PP_ONE_MORE) ? `PP_HOLD_NEXT : pp_eff;
						end
					end
				end
				flash_fetch_pkg::ST_HOLD: begin
					if (!page_low && slow_edge) begin
						st <= flash_fetch_pkg::ST_BURST;
						cnt <= len_m1(hcfg.burst_cycle_count);
					end
				end
				flash_fetch_pkg::ST_RECOV: begin
					if (cnt != `CNT_ZERO) begin
						cnt <= cnt - `BEAT_ONE;
					end else if (words_left == 8'h00) begin
						if (caps_clear) begin
							st <= flash_fetch_pkg::ST_IDLE;
							term <= 1'b0;
							done_tgl <= !done_tgl;
						end
					end else if (slow_edge) begin
						st <= flash_fetch_pkg::ST_ADDR;
						cnt <= len_m1(hcfg.addr_cnt);
						beats <= `CNT_ZERO;
						term <= 1'b0;
						last_cs <= hreq.region_chip_select;
						cs_valid <= 1'b1;
					end
				end
				default: begin
					st <= flash_fetch_pkg::ST_IDLE;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// pin outputs
	wire in_access = (st != flash_fetch_pkg::ST_IDLE) && (st != flash_fetch_pkg::ST_RECOV);
	wire reading = (st == flash_fetch_pkg::ST_CMD) || (st == flash_fetch_pkg::ST_BURST);
	wire [7:0] cs_sel = `CS_ONE << last_cs;
	logic adv_q;
	logic baa_q;
	logic adv_neg;
	logic baa_neg;

	always_ff @(posedge fast_bus_clk_in) begin
		if (rst_l) begin
			flash_cs_n_out <= `CS_ALL_OFF;
			flash_rd_n_out <= 1'b1;
			flash_addr_out <= 23'h000000;
			adv_q <= 1'b1;
			baa_q <= 1'b1;
		end else begin
			flash_cs_n_out <= in_access ? ~cs_sel : `CS_ALL_OFF;
			flash_rd_n_out <= !reading;
			flash_addr_out <= addr[23:1];
			adv_q <= !(st == flash_fetch_pkg::ST_ADDR);
			baa_q <= !(st == flash_fetch_pkg::ST_BURST);
		end
	end

	// falling edge copies give the half cycle strobe delay
	always_ff @(negedge fast_bus_clk_in) begin
		if (rst_l) begin
			adv_neg <= 1'b1;
			baa_neg <= 1'b1;
		end else begin
			adv_neg <= adv_q;
			baa_neg <= baa_q;
		end
	end

	assign address_valid_strobe_n_out = hcfg.strobe_delay_bypass ? adv_q : adv_neg;
	assign burst_advance_strobe_n_out = hcfg.strobe_delay_bypass ? baa_q : baa_neg;

	////////////////////////////////////////////////////////////////////////
	// checks
	property p_addr_align;
		@(posedge fast_bus_clk_in) disable iff (rst_l)
		(st == flash_fetch_pkg::ST_ADDR && $past(st) != flash_fetch_pkg::ST_ADDR)
			|-> $past(slow_edge);
	endproperty
	a_addr_align: assert property (p_addr_align) else $error("address phase off slow edge");

	property p_resume_align;
		@(posedge fast_bus_clk_in) disable iff (rst_l)
		(st == flash_fetch_pkg::ST_BURST && $past(st) == flash_fetch_pkg::ST_HOLD)
			|-> $past(slow_edge) && $past(wait_slow);
	endproperty
	a_resume_align: assert property (p_resume_align) else $error("resume not aligned");

	property p_no_hold_when_off;
		@(posedge fast_bus_clk_in) disable iff (rst_l)
		!wait_on |-> st != flash_fetch_pkg::ST_HOLD && !term;
	endproperty
	a_no_hold_when_off: assert property (p_no_hold_when_off) else $error("wait acted while off");

	property p_beat_limit;
		@(posedge fast_bus_clk_in) disable iff (rst_l)
		bp_end && !hcfg.continuous_burst_select && beats_inc == blen
			|=> st == flash_fetch_pkg::ST_RECOV;
	endproperty
	a_beat_limit: assert property (p_beat_limit) else $error("burst limit overrun");

	property p_cs_release;
		@(posedge fast_bus_clk_in) disable iff (rst_l)
		bp_end && words_left == 8'h01 |=> ##1 flash_cs_n_out == `CS_ALL_OFF;
	endproperty
	a_cs_release: assert property (p_cs_release) else $error("cs held after last word");

	property p_cmd_after_addr;
		@(posedge fast_bus_clk_in) disable iff (rst_l)
		st == flash_fetch_pkg::ST_CMD |-> $past(st) == flash_fetch_pkg::ST_CMD
			|| $past(st) == flash_fetch_pkg::ST_CDLY || $past(st) == flash_fetch_pkg::ST_ADDR;
	endproperty
	a_cmd_after_addr: assert property (p_cmd_after_addr) else $error("command phase out of order");

	property p_term_ends;
		@(posedge fast_bus_clk_in) disable iff (rst_l)
		bp_end && term |=> st == flash_fetch_pkg::ST_RECOV;
	endproperty
	a_term_ends: assert property (p_term_ends) else $error("terminate ignored");

	property p_restart_addr;
		@(posedge fast_bus_clk_in) disable iff (rst_l)
		bp_end |=> addr == $past(addr) + $past(step);
	endproperty
	a_restart_addr: assert property (p_restart_addr) else $error("address not sequential");

	property p_strobe_delay;
		@(posedge fast_bus_clk_in) disable iff (rst_l)
		(st == flash_fetch_pkg::ST_ADDR && $past(st) != flash_fetch_pkg::ST_ADDR)
			|=> !address_valid_strobe_n_out;
	endproperty
	a_strobe_delay: assert property (p_strobe_delay) else $error("address strobe missing");

	property p_div_range;
		@(posedge fast_bus_clk_in) disable iff (rst_l)
		div_cnt <= div_max;
	endproperty
	a_div_range: assert property (p_div_range) else $error("divider out of range");
endmodule

// *** rtl/flash_fetch_defs.svh ***
// Purpose: constants for the burst flash fetch sequencer
// Assumes: included by its bare name
// Notes: encodings of the config struct live in the package
`ifndef FLASH_FETCH_DEFS_SVH
`define FLASH_FETCH_DEFS_SVH
`define ADDR_STEP_16 24'h000002
`define ADDR_STEP_32 24'h000004
`define CS_ALL_OFF 8'hff
`define CS_ONE 8'h01
`define BEAT_ONE 4'h1
`define CNT_ZERO 4'h0
`define DIV_ZERO 2'h0
`define PP_NONE 2'h0
`define PP_HOLD_NEXT 2'h1
`define PP_ONE_MORE 2'h2
`endif

// *** rtl/flash_fetch_pkg.sv ***
// Purpose: types shared by the burst flash fetch sequencer
// Assumes: nothing
// Notes: counts are 4 bits, zero length phases clamp as noted in the design
package flash_fetch_pkg;
	typedef enum logic [1:0] {
		WAIT_OFF = 2'b00,
		WAIT_SYNC = 2'b01,
		WAIT_ASYNC = 2'b10
	} wait_mode_e;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_ADDR = 3'b001,
		ST_CDLY = 3'b010,
		ST_CMD = 3'b011,
		ST_BURST = 3'b100,
		ST_HOLD = 3'b101,
		ST_RECOV = 3'b110
	} link_state_e;

	typedef struct packed {
		logic [3:0] addr_cnt;
		logic [3:0] command_delay_count;
		logic [3:0] read_wait_count;
		logic [3:0] burst_cycle_count;
		logic [3:0] read_recovery_count;
		logic [3:0] cs_change_recovery_count;
		logic [1:0] fetch_burst_length;
		logic continuous_burst_select;
		logic wait_func;
		wait_mode_e wait_mode;
		logic strobe_delay_bypass;
		logic port_width;
		logic [1:0] clk_div;
	} flash_cfg_s;

	typedef struct packed {
		logic [23:0] addr;
		logic [7:0] words;
		logic [2:0] region_chip_select;
	} fetch_req_s;
endpackage

// *** verification/burst_flash_model.sv ***
// Purpose: burst flash partner for the fetch sequencer
// Assumes: flash already switched to synchronous mode by software
// Notes: word follows an internal counter, wait held low on command
`timescale 1ns/1ps
module burst_flash_model (
	input wire logic dev_clk_in,
	input wire logic [7:0] cs_n_in,
	input wire logic adv_n_in,
	input wire logic [23:1] addr_in,
	input wire logic hold_wait_in,
	output logic [31:0] data_out,
	output logic wait_n_out
);
	logic [31:0] word = 32'h0;
	wire sel = cs_n_in != 8'hff;
	//////////////////////////////////////////////////////////////
	always @(posedge dev_clk_in) begin
		if (!adv_n_in)
			word <= {9'h0, addr_in};
		else
			word <= word + 32'h1;
	end
	// a released bus must not look like a stale valid word
	assign data_out = sel ? word : ~word;
	assign wait_n_out = !(sel && hold_wait_in);
endmodule

// *** verification/burst_flash_fetch_sequencer_tb.sv ***
// Purpose: self-checking bench for the burst fetch sequencer
// Assumes: bus clock 160 ns, core clock 10 ns
// Notes: reset held long enough for the bus domain to see it
`timescale 1ns/1ps
module burst_flash_fetch_sequencer_tb;
	logic core_clk = 0, sys_rst = 1, bus_clk = 0, req = 0, hold_w = 0;
	flash_fetch_pkg::fetch_req_s fin = '0;
	flash_fetch_pkg::flash_cfg_s cfg = '0;
	logic rdy, dv, done, advn, dclk, wn, son = 0, prev_on = 0, rdn, baan, fbc;
	logic [31:0] dout, fdata;
	logic [23:1] fa;
	logic [7:0] csn;
	int failures = 0, compares = 0, acc, gap, min_gap, nwords, per_acc, i;
	realtime last_rise, t0;
	always #5 core_clk = ~core_clk;
	initial begin
		#3;
		forever #80 bus_clk = ~bus_clk;
	end
	burst_flash_fetch_sequencer i_burst_flash_fetch_sequencer (.core_clk_in(core_clk),
		.sys_rst_in(sys_rst), .fast_bus_clk_in(bus_clk), .fetch_req_in(req), .fetch_in(fin),
		.cfg_in(cfg), .fetch_ready_out(rdy), .fetch_data_out(dout), .fetch_data_valid_out(dv),
		.fetch_done_out(done), .flash_data_in(fdata), .flash_wait_n_in(wn),
		.flash_addr_out(fa), .flash_cs_n_out(csn), .flash_rd_n_out(rdn),
		.address_valid_strobe_n_out(advn), .burst_advance_strobe_n_out(baan),
		.fast_bus_clock_out(fbc), .device_clock_out(dclk));
	burst_flash_model i_burst_flash_model (.dev_clk_in(dclk), .cs_n_in(csn),
		.adv_n_in(advn), .addr_in(fa), .hold_wait_in(hold_w), .data_out(fdata),
		.wait_n_out(wn));
	//////////////////////////////////////////////////////////////
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			failures++;
			$display("unexpected at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask
	task automatic close_out;
		if (failures == 0 && compares > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic fetch(input logic [23:0] a, input logic [7:0] n, input logic [2:0] r,
		input int ex);
		int t;
		while (rdy !== 1'b1) @(posedge core_clk);
		acc = 0;
		nwords = 0;
		min_gap = 99;
		per_acc = n / ex;
		fin <= '{addr: a, words: n, region_chip_select: r};
		req <= 1'b1;
		@(posedge core_clk);
		req <= 1'b0;
		for (t = 0; t < 40000 && done !== 1'b1; t++) @(posedge core_clk);
		check(done, 1'b1);
		check(nwords, n);
		check(acc, ex);
		if (acc > 1) check(min_gap >= cfg.read_recovery_count, 1'b1);
	endtask
	//////////////////////////////////////////////////////////////
	// access count, recovery gap, start address and select of each access
	// pins move on the rising bus edge, so they are read on the falling one
	always @(negedge bus_clk) begin
		son <= csn != 8'hff;
		if (csn === 8'hff) check(rdn, 1'b1);
		if (csn != 8'hff && !son) check(rdn, 1'b1);
		gap <= (csn != 8'hff) ? 0 : gap + 1;
		if (csn != 8'hff) check({24'h0, csn}, {24'h0, ~(8'h01 << fin.region_chip_select)});
		if (csn != 8'hff && !son) begin
			acc <= acc + 1;
			check({9'h0, fa}, fin.addr[23:1] + acc * per_acc * (cfg.port_width ? 2 : 1));
			if (acc > 0 && gap < min_gap) min_gap <= gap;
		end
	end
	always @(posedge core_clk) begin
		if (dv === 1'b1) nwords <= nwords + 1;
		if (dv === 1'b1 && !cfg.port_width) check(dout[31:16], 32'h0);
	end
	// the strobe edge shows which bus clock edge launched it
	always @(negedge advn or negedge baan) begin
		#1;
		check(bus_clk, cfg.strobe_delay_bypass);
		check(fbc, bus_clk);
	end
	always @(posedge dclk) begin
		if (son && prev_on) check(int'($realtime - last_rise), 160 * (cfg.clk_div + 1));
		prev_on = son;
		last_rise = $realtime;
	end
	//////////////////////////////////////////////////////////////
	initial begin
		repeat (64) @(posedge core_clk);
		sys_rst <= 1'b0;
		repeat (64) @(posedge core_clk);
		cfg.addr_cnt <= 4'h2;
		cfg.command_delay_count <= 4'h1;
		cfg.read_wait_count <= 4'h2;
		cfg.burst_cycle_count <= 4'h1;
		cfg.read_recovery_count <= 4'h3;
		cfg.cs_change_recovery_count <= 4'h2;
		for (i = 0; i < 4; i++) begin
			cfg.clk_div <= i[1:0];
			cfg.fetch_burst_length <= i[1:0];
			cfg.strobe_delay_bypass <= i[0];
			fetch(24'h000100, 8'h08, i[2:0], 8 >> i);
		end
		cfg.port_width <= 1'b1;
		cfg.fetch_burst_length <= 2'h2;
		fetch(24'h000200, 8'h04, 3'h5, 1);
		cfg.port_width <= 1'b0;
		cfg.continuous_burst_select <= 1'b1;
		cfg.fetch_burst_length <= 2'h0;
		fetch(24'h000300, 8'h06, 3'h5, 1);
		cfg.continuous_burst_select <= 1'b0;
		cfg.fetch_burst_length <= 2'h3;
		cfg.wait_func <= 1'b1;
		hold_w <= 1'b1;
		fetch(24'h000400, 8'h08, 3'h2, 1);
		for (i = 1; i < 3; i++) begin
			cfg.wait_mode <= flash_fetch_pkg::wait_mode_e'(i);
			fetch(24'h000500, 8'h08, 3'h2, 8);
		end
		cfg.wait_func <= 1'b0;
		t0 = $realtime;
		fork
			#20000 hold_w <= 1'b0;
		join_none
		fetch(24'h000600, 8'h08, 3'h2, 1);
		check($realtime - t0 > 20000, 1'b1);
		close_out();
	end
	initial begin
		#900000;
		failures++;
		close_out();
	end
endmodule
